/* File: hw/hbp_host_port.sv */
// Purpose: 8-bit host processor port serving both bus styles
// Assumes: host pins are asynchronous and pass two flip-flops first
// Notes:   one decode covers both styles, so no style pin exists
`default_nettype none

// How it works
// [RL1] both bus styles served, no style pin
// [RL2] combined style: host ties enable low
// [RL3] strobe style: host strobes on enable, direction
// [RL4] drive data when select and enable low; code also needs direction high
// [RL5] combined style: capture at select rising
// [RL6] strobe style: capture at strobe rising
// [RL7] move held value inside two cycles
// [RL8] host leaves two select-high cycles after writes
// [RL9] write while select and direction low
module hbp_host_port
    import hbp_pkg::*;
#(
    parameter int unsigned AW = ADDR_W,
    parameter int unsigned DW = DATA_W
)
(
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          ce,
    input  wire logic          hostCs_n,
    input  wire logic          hostRw_n,
    input  wire logic          hostOe_n,
    input  wire logic [AW-1:0] hostAddr,
    input  wire logic [DW-1:0] hostDataIn,
    output var  logic [DW-1:0] hostDataOut,
    output var  logic          hostDataOe_n,
    output var  logic          regUpdate,
    output var  logic [AW-1:0] regUpdateAddr,
    output var  logic [DW-1:0] regUpdateData,
    output var  logic          spacingFault
);

    // synchroniser stages; stage one feeds stage two only
    logic          csMeta;
    logic          rwMeta;
    logic          oeMeta;
    logic [AW-1:0] addrMeta;
    logic [DW-1:0] dataMeta;
    logic          csSync;
    logic          rwSync;
    logic          oeSync;
    logic [AW-1:0] addrSync;
    logic [DW-1:0] dataSync;

    logic          writeReq;
    logic          readReq;
    hbp_state_t    state;
    hbp_state_t    next_state;
    logic [DW-1:0] holdData;
    logic [AW-1:0] holdAddr;
    logic [DW-1:0] memRdData;
    logic          memWrEn;
    logic          gapOpen;
    logic [GAP_CNT_W-1:0] gapCount;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            csMeta   <= PIN_IDLE;
            rwMeta   <= PIN_IDLE;
            oeMeta   <= PIN_IDLE;
            addrMeta <= '0;
            dataMeta <= '0;
            csSync   <= PIN_IDLE;
            rwSync   <= PIN_IDLE;
            oeSync   <= PIN_IDLE;
            addrSync <= '0;
            dataSync <= '0;
        end
        else if (ce)
        begin
            csMeta   <= hostCs_n;
            rwMeta   <= hostRw_n;
            oeMeta   <= hostOe_n;
            addrMeta <= hostAddr;
            dataMeta <= hostDataIn;
            csSync   <= csMeta;
            rwSync   <= rwMeta;
            oeSync   <= oeMeta;
            addrSync <= addrMeta;
            dataSync <= dataMeta;
        end
    end

    // a write strobe is low direction under low select in either style,
    // so the end of that condition is the rising select or strobe edge
    assign writeReq = !csSync && !rwSync;                       // [RL9] [RL1]
    // combined style holds enable low, so select low with direction high opens a read
    assign readReq  = !csSync && rwSync && !oeSync;       // [RL4] [RL2] [RL3]

    always_comb
    begin
        next_state = state;
        case (state)
            HBP_IDLE:
            begin
                if (writeReq)
                begin
                    next_state = HBP_WRITE;
                end
                else if (readReq)
                begin
                    next_state = HBP_READ;
                end
            end
            HBP_READ:
            begin
                if (!readReq)
                begin
                    next_state = HBP_IDLE;
                end
            end
            HBP_WRITE:
            begin
                if (!writeReq)
                begin
                    next_state = HBP_MOVE;                     // [RL5] [RL6]
                end
            end
            HBP_MOVE:
            begin
                next_state = HBP_IDLE;
            end
            default:
            begin
                next_state = HBP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state <= HBP_IDLE;
        end
        else if (ce)
        begin
            state <= next_state;
        end
    end

    // holding register follows the bus while the strobe is low; the
    // value seen in the last low cycle is what the rising edge keeps
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            holdData <= DATA_RESET[DW-1:0];
            holdAddr <= '0;
        end
        else if (ce && writeReq)
        begin
            holdData <= dataSync;                              // [RL5] [RL6]
            holdAddr <= addrSync;
        end
    end

    // move happens in the cycle after the edge is seen
    assign memWrEn = (state == HBP_MOVE);                             // [RL7]

    hbp_reg_mem #(
        .AW (AW),
        .DW (DW)
    ) u_mem (
        .clk    (clk),
        .rst    (rst),
        .ce     (ce),
        .wrEn   (memWrEn),
        .wrAddr (holdAddr),
        .wrData (holdData),
        .rdAddr (addrSync),
        .rdData (memRdData)
    );

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            regUpdate     <= 1'b0;
            regUpdateAddr <= '0;
            regUpdateData <= DATA_RESET[DW-1:0];
        end
        else if (ce)
        begin
            regUpdate <= memWrEn;                                     // [RL7]
            if (memWrEn)
            begin
                regUpdateAddr <= holdAddr;
                regUpdateData <= holdData;
            end
        end
    end

    // bus released as soon as the read condition drops
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            hostDataOut  <= DATA_RESET[DW-1:0];
            hostDataOe_n <= 1'b1;
        end
        else if (ce)
        begin
            hostDataOe_n <= !(state == HBP_READ && readReq);          // [RL4]
            hostDataOut  <= memRdData;
        end
    end

    // watch the select-high gap owed after a write; a short gap is
    // flagged, not blocked, since the access already started
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            gapOpen      <= 1'b0;
            gapCount     <= '0;
            spacingFault <= 1'b0;
        end
        else if (ce)
        begin
            spacingFault <= 1'b0;
            if (memWrEn)
            begin
                gapOpen  <= 1'b1;
                gapCount <= csSync ? GAP_CNT_W'(1) : '0;
            end
            else if (gapOpen)
            begin
                if (!csSync)
                begin
                    gapOpen      <= 1'b0;
                    spacingFault <= (gapCount < GAP_CNT_W'(WRITE_GAP)); // [RL8]
                end
                else if (gapCount >= GAP_CNT_W'(WRITE_GAP))
                begin
                    gapOpen <= 1'b0;
                end
                else
                begin
                    gapCount <= gapCount + GAP_CNT_W'(1);
                end
            end
        end
    end

endmodule : hbp_host_port

`default_nettype wire

/* File: hw/hbp_pkg.sv */
// Purpose: shared constants and types of the dual style host bus port
// Assumes: one system clock, synchronous active-high reset
// Notes:   widths here are defaults; modules take them as parameters
`default_nettype none

package hbp_pkg;

    localparam int unsigned ADDR_W       = 6;
    localparam int unsigned DATA_W       = 8;
    localparam int unsigned SYNC_STAGES  = 2;
    localparam real         CLK_PERIOD_NS = 40.0;
    // cycles the held value may take to reach the internal register
    localparam int unsigned MOVE_CYCLES  = 2;
    // select-high cycles the host owes after a write
    localparam int unsigned WRITE_GAP    = 2;
    localparam int unsigned GAP_CNT_W    = 2;
    localparam logic [7:0]  DATA_RESET   = 8'h00;
    localparam logic        PIN_IDLE     = 1'b1;

    typedef enum logic [1:0]
    {
        HBP_IDLE  = 2'b00,
        HBP_READ  = 2'b01,
        HBP_WRITE = 2'b10,
        HBP_MOVE  = 2'b11
    } hbp_state_t;

endpackage : hbp_pkg

`default_nettype wire

/* File: hw/hbp_reg_mem.sv */
// Purpose: internal register file reached through the host port
// Assumes: one write port, one read port, read data registered
// Notes:   contents clear to zero under reset
`default_nettype none

module hbp_reg_mem
    import hbp_pkg::*;
#(
    parameter int unsigned AW = ADDR_W,
    parameter int unsigned DW = DATA_W
)
(
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          ce,
    input  wire logic          wrEn,
    input  wire logic [AW-1:0] wrAddr,
    input  wire logic [DW-1:0] wrData,
    input  wire logic [AW-1:0] rdAddr,
    output var  logic [DW-1:0] rdData
);

    logic [DW-1:0] store [0:(1<<AW)-1];

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < (1 << AW); i++)
            begin
                store[i] <= '0;
            end
        end
        else if (ce && wrEn)
        begin
            store[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rdData <= '0;
        end
        else if (ce)
        begin
            rdData <= store[rdAddr];
        end
    end

endmodule : hbp_reg_mem

`default_nettype wire

/* File: sim/dual_style_host_bus_port_bench.sv */
// Purpose: self-checking bench of the host port
// Assumes: ce tied high, one clock
// Notes:   expected bytes come from the values written
`default_nettype none
module dual_style_host_bus_port_bench
    import hbp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       hostCs_n, hostRw_n, hostOe_n, hostDataOe_n;
    logic       regUpdate, spacingFault;
    logic [5:0] hostAddr, regUpdateAddr;
    logic [7:0] hostDataIn, hostDataOut, regUpdateData, d;
    int         miscompares = 0, num_checks = 0, cycles = 0, faults = 0;

    always #20 clk = ~clk;
    hbp_host_port u_dut (.clk, .rst, .ce(1'b1), .hostCs_n, .hostRw_n,
        .hostOe_n, .hostAddr, .hostDataIn, .hostDataOut, .hostDataOe_n,
        .regUpdate, .regUpdateAddr, .regUpdateData, .spacingFault);
    hbp_host_model u_host (.clk, .devData(hostDataOut),
        .devOe_n(hostDataOe_n), .cs_n(hostCs_n), .rw_n(hostRw_n),
        .oe_n(hostOe_n), .addr(hostAddr), .busData(hostDataIn));

    task automatic check(input string what, input logic [7:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic end_of_test();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    always @(posedge clk)
    begin
        cycles++;
        if (spacingFault === 1'b1) faults++;
        // far above the ~100 cycles the tests need
        if (cycles == 3000)
        begin
            miscompares++;
            end_of_test();
        end
    end

    task automatic t_reset();
        check("oe", hostDataOe_n, 1'b1);
        check("upd", regUpdate, 1'b0);
        u_host.rd(1'b0, 6'h10, d);
        check("blank", d, 8'h00);
    endtask : t_reset

    // write in one style, read back in the other: no style pin
    task automatic t_styles();
        for (int s = 0; s < 2; s++)
        begin
            u_host.wr(s[0], 6'h3F - s[5:0], 8'hA5 + s[7:0], 4);
            check("addr", regUpdateAddr, 6'h3F - s[5:0]);
            check("data", regUpdateData, 8'hA5 + s[7:0]);
            u_host.rd(!s[0], 6'h3F - s[5:0], d);
            check("read", d, 8'hA5 + s[7:0]);
        end
    endtask : t_styles

    task automatic t_gap();
        u_host.wr(1'b1, 6'h00, 8'h3C, 0);
        u_host.wr(1'b1, 6'h01, 8'hC3, 4);
        check("fault", faults[7:0], 8'h01);
        u_host.rd(1'b0, 6'h00, d);
        check("first", d, 8'h3C);
        u_host.rd(1'b1, 6'h01, d);
        check("second", d, 8'hC3);
    endtask : t_gap

    initial
    begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_styles();
        t_gap();
        end_of_test();
    end
endmodule : dual_style_host_bus_port_bench
`default_nettype wire

/* File: sim/hbp_host_model.sv */
// Purpose: host processor driving the port in either bus style
// Assumes: pins change at falling edges only
// Notes:   released data shows the inverse of the last byte
`default_nettype none
module hbp_host_model
    import hbp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [7:0] devData,
    input  wire logic       devOe_n,
    output var  logic       cs_n,
    output var  logic       rw_n,
    output var  logic       oe_n,
    output var  logic [5:0] addr,
    output var  logic [7:0] busData
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] drv;
    initial {cs_n, rw_n, oe_n, addr, drv} = {3'b111, 6'h00, 8'h00};
    assign busData = devOe_n ? drv : devData;

    task automatic wr(input logic strobe, input logic [5:0] a,
                      input logic [7:0] d, input int gap);
        @(negedge clk);
        // strobe style keeps the read strobe high; combined ties it low
        {oe_n, addr, drv} = {strobe, a, d};
        if (strobe) cs_n = 1'b0; else rw_n = 1'b0;
        @(negedge clk);
        if (strobe) rw_n = 1'b0; else cs_n = 1'b0;
        repeat (4) @(negedge clk);
        if (strobe) rw_n = 1'b1; else cs_n = 1'b1;
        @(negedge clk);
        {cs_n, rw_n, drv} = {2'b11, ~d};
        repeat (gap) @(negedge clk);
    endtask : wr

    task automatic rd(input logic strobe, input logic [5:0] a,
                      output logic [7:0] d);
        @(negedge clk);
        {cs_n, rw_n, oe_n, addr} = {3'b010, a};
        for (int i = 0; i < 9 && devOe_n !== 1'b0; i++) @(negedge clk);
        d = devData;
        {cs_n, oe_n} = {1'b1, strobe};
        repeat (3) @(negedge clk);
    endtask : rd
endmodule : hbp_host_model
`default_nettype wire

/* File: sim/hbp_port_chk_sva.sv */
// Purpose: pin-level checks of the host port
// Assumes: ce high, host pins pass two sync flops
// Notes:   figures count rising edges from the pin sample
`default_nettype none
module hbp_port_chk
    import hbp_pkg::*;
#(
    parameter int unsigned AW = ADDR_W,
    parameter int unsigned DW = DATA_W
)
(
    input wire logic          clk,
    input wire logic          rst,
    input wire logic          hostCs_n,
    input wire logic          hostRw_n,
    input wire logic          hostOe_n,
    input wire logic [AW-1:0] hostAddr,
    input wire logic [DW-1:0] hostDataIn,
    input wire logic          hostDataOe_n,
    input wire logic          regUpdate,
    input wire logic [AW-1:0] regUpdateAddr,
    input wire logic [DW-1:0] regUpdateData,
    input wire logic          spacingFault
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wrPin;
    logic rdPin;
    assign wrPin = !hostCs_n && !hostRw_n;
    assign rdPin = !hostCs_n && !hostOe_n && hostRw_n;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_write_update: assert property (
        $past(wrPin) && !wrPin |-> ##4 regUpdate)
        else $error("no update after write end");
    a_update_data: assert property (
        regUpdate |-> $past(wrPin, 5) && regUpdateData == $past(hostDataIn, 5)
        && regUpdateAddr == $past(hostAddr, 5))
        else $error("update not from last write sample");
    a_update_pulse: assert property (
        regUpdate |=> !regUpdate)
        else $error("update longer than one cycle");
    a_read_drive: assert property (
        rdPin && !$past(rdPin) ##1 rdPin |-> ##3 !hostDataOe_n)
        else $error("read not driven");
    a_read_release: assert property (
        !rdPin [*4] |-> hostDataOe_n)
        else $error("bus driven without read");
    a_write_quiet: assert property (
        wrPin [*3] |-> hostDataOe_n)
        else $error("bus driven during write");
    c_write: cover property (regUpdate);
    c_read: cover property (rdPin && !hostDataOe_n);
    c_fault: cover property (spacingFault);
endmodule : hbp_port_chk
bind hbp_host_port hbp_port_chk #(.AW(AW), .DW(DW)) u_chk (.clk, .rst,
    .hostCs_n, .hostRw_n, .hostOe_n, .hostAddr, .hostDataIn, .hostDataOe_n,
    .regUpdate, .regUpdateAddr, .regUpdateData, .spacingFault);
`default_nettype wire
